/* inc/psr_pkg.sv */
package psr_pkg;

    // Field positions inside the status word
    localparam int PSR_N_BIT = 31;
    localparam int PSR_Z_BIT = 30;
    localparam int PSR_C_BIT = 29;
    localparam int PSR_V_BIT = 28;
    localparam int PSR_Q_BIT = 27;
    localparam int PSR_XS_HI_MSB = 26;
    localparam int PSR_T_BIT = 24;
    localparam int PSR_GE_MSB = 19;
    localparam int PSR_XS_LO_MSB = 15;
    localparam int PSR_RESUME_MSB = 15;
    localparam int PSR_EXC_MSB = 8;
    localparam int PSR_EXC_W = 9;

    // Software view select bits
    localparam int PSR_SEL_FLAGS = 0;
    localparam int PSR_SEL_EXC = 1;
    localparam int PSR_SEL_EXEC = 2;

    // Bits that a software read may see per view
    localparam logic [31:0] PSR_FLAGS_MASK = 32'hF80F0000;
    localparam logic [31:0] PSR_EXC_MASK = 32'h000001FF;

    // Reset values
    localparam logic [4:0] PSR_NZCVQ_RST = 5'h00;
    localparam logic [3:0] PSR_GE_RST = 4'h0;
    localparam logic PSR_T_RST = 1'b1;
    localparam logic [7:0] PSR_COND_RST = 8'h00;
    localparam logic [3:0] PSR_RESUME_RST = 4'h0;

    // Exception numbers
    localparam logic [8:0] PSR_EXC_THREAD = 9'h000;
    localparam logic [8:0] PSR_EXC_NMI = 9'h002;
    localparam logic [8:0] PSR_EXC_HARD = 9'h003;
    localparam logic [8:0] PSR_EXC_MEM = 9'h004;
    localparam logic [8:0] PSR_EXC_BUS = 9'h005;
    localparam logic [8:0] PSR_EXC_USAGE = 9'h006;
    localparam logic [8:0] PSR_EXC_SVC = 9'h00B;
    localparam logic [8:0] PSR_EXC_PEND = 9'h00E;
    localparam logic [8:0] PSR_EXC_TICK = 9'h00F;
    localparam logic [8:0] PSR_EXC_IRQ_BASE = 9'h010;
    localparam logic [8:0] PSR_EXC_MAX = 9'h0FF;

    // Use of the shared execution-state bits
    typedef enum logic [1:0] {
        PSR_XS_NONE = 2'b00,
        PSR_XS_COND = 2'b01,
        PSR_XS_RESUME = 2'b11
    } psr_xs_e;

endpackage : psr_pkg

/* inc/psr_upd_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface psr_upd_if;
    // Flag update group
    logic nzcv_we;
    logic [3:0] nzcv;
    logic ge_we;
    logic [3:0] ge;
    logic sat_evt;
    logic sw_wr;
    logic sw_wr_ge;
    logic [31:0] sw_wdata;
    logic [4:0] cur_nzcvq;
    logic [3:0] cur_ge;
    logic [4:0] next_nzcvq;
    logic [3:0] next_ge;
    // Exception number group
    logic enter;
    logic is_irq;
    logic [8:0] num_in;
    logic leave;
    logic [8:0] ret_num;
    logic [8:0] cur_num;
    logic [8:0] next_num;
    logic accept;
    logic reject;

    modport top_mp (
        output nzcv_we, nzcv, ge_we, ge, sat_evt, sw_wr, sw_wr_ge, sw_wdata, cur_nzcvq, cur_ge,
        input next_nzcvq, next_ge,
        output enter, is_irq, num_in, leave, ret_num, cur_num,
        input next_num, accept, reject
    );
    modport flag_mp (
        input nzcv_we, nzcv, ge_we, ge, sat_evt, sw_wr, sw_wr_ge, sw_wdata, cur_nzcvq, cur_ge,
        output next_nzcvq, next_ge
    );
    modport exc_mp (
        input enter, is_irq, num_in, leave, ret_num, cur_num,
        output next_num, accept, reject
    );
endinterface : psr_upd_if
`default_nettype wire

/* rtl/psr_exc_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module psr_exc_unit #(
    parameter int NUM_IRQ = 240
) (
    // Exception number group
    psr_upd_if.exc_mp e
);
    import psr_pkg::*;

    // Candidate number on entry
    logic [8:0] cand;

    // True for a number that a handler may carry
    function automatic logic num_legal(input logic [8:0] n);
        logic ok;
        ok = 1'b0;
        case (n)
            PSR_EXC_NMI, PSR_EXC_HARD, PSR_EXC_MEM, PSR_EXC_BUS, PSR_EXC_USAGE,
            PSR_EXC_SVC, PSR_EXC_PEND, PSR_EXC_TICK: ok = 1'b1;
            default: ok = (n >= PSR_EXC_IRQ_BASE) && (n <= PSR_EXC_MAX)
                && ({23'h0, n} < (32'(PSR_EXC_IRQ_BASE) + 32'(NUM_IRQ)));
        endcase
        return ok;
    endfunction : num_legal

    // Entry beats exit; illegal numbers leave the field alone
    always_comb begin
        cand = e.is_irq ? 9'(PSR_EXC_IRQ_BASE + e.num_in) : e.num_in;
        e.next_num = e.cur_num;
        e.accept = 1'b0;
        e.reject = 1'b0;
        if (e.enter) begin
            // Line index beyond the product's count is refused
            if (num_legal(cand) && !(e.is_irq && (32'(e.num_in) >= 32'(NUM_IRQ)))) begin
                e.next_num = cand;
                e.accept = 1'b1;
            end else begin
                e.reject = 1'b1;
            end
        end else if (e.leave) begin
            // Return to thread mode or to a legal preempted handler
            if ((e.ret_num == PSR_EXC_THREAD) || num_legal(e.ret_num)) begin
                e.next_num = e.ret_num;
            end else begin
                e.reject = 1'b1;
            end
        end
    end

endmodule : psr_exc_unit
`default_nettype wire

/* rtl/psr_flag_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module psr_flag_unit (
    // Flag update group
    psr_upd_if.flag_mp f
);
    import psr_pkg::*;

    // Next flags; execute updates beat a software write in the same cycle
    always_comb begin
        f.next_nzcvq = f.cur_nzcvq;
        f.next_ge = f.cur_ge;
        // Software move only reaches flag bits
        if (f.sw_wr) begin
            f.next_nzcvq = f.sw_wdata[PSR_N_BIT -: 5];
            if (f.sw_wr_ge) begin
                f.next_ge = f.sw_wdata[PSR_GE_MSB -: 4];
            end
        end
        // N Z C V come as one result from the flag-setting operation
        if (f.nzcv_we) begin
            f.next_nzcvq[4:1] = f.nzcv;
        end
        // Byte lane compare results
        if (f.ge_we) begin
            f.next_ge = f.ge;
        end
        // Saturation sets last so it wins over a software clear
        if (f.sat_evt) begin
            f.next_nzcvq[0] = 1'b1;
        end
    end

endmodule : psr_flag_unit
`default_nettype wire

/* rtl/psr_top.sv */
// What this block does
// - Execution-state view reads zero, ignores writes
// - Negative flag at bit 31
// - Zero flag at bit 30
// - Carry flag at bit 29, no-borrow is one
// - Overflow flag at bit 28
// - Sticky saturation bit 27, hardware never clears
// - Only software write clears saturation; reset zero
// - Four byte-lane compare flags at 19:16
// - Exception number in 8:0, zero in thread
// - System exception numbers 2..15 as listed
// - Reserved exception numbers never reported
// - Interrupt line k reports 16 plus k
// - Instruction-set state bit at bit 24
// - Shared bits hold interrupted multi-transfer state
// - Shared bits hold conditional block state instead
// - Exception entry stacks the complete status word
// - Software writes to exception number ignored
// - Multi-transfer resume register stored in 15:12
// - Resume state keeps 26:25 and 11:10 zero
`timescale 1ns/100ps
`default_nettype none
module psr_top #(
    parameter int NUM_IRQ = 240
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Flag updates from execute
    input wire logic nzcv_we,
    input wire logic [3:0] nzcv_in,
    input wire logic ge_we,
    input wire logic [3:0] ge_in,
    input wire logic sat_evt,
    // Exception entry and return
    input wire logic exc_enter,
    input wire logic exc_is_irq,
    input wire logic [8:0] exc_num_in,
    input wire logic exc_exit,
    input wire logic [8:0] exc_ret_num,
    // Execution state updates
    input wire logic t_we,
    input wire logic t_in,
    input wire logic xs_we,
    input wire psr_pkg::psr_xs_e xs_mode_in,
    input wire logic [7:0] xs_cond_in,
    input wire logic [3:0] xs_resume_in,
    // Software status moves
    input wire logic sw_rd,
    input wire logic sw_wr,
    input wire logic [2:0] sw_sel,
    input wire logic sw_wr_ge,
    input wire logic [31:0] sw_wdata,
    // Results
    output logic [31:0] sw_rdata,
    output logic sw_rvalid,
    output logic [31:0] psr_word,
    output logic [8:0] exc_num,
    output logic [31:0] stack_word,
    output logic stack_valid,
    output logic exc_reject
);
    import psr_pkg::*;

    // Link to the two helper units
    psr_upd_if u ();

    // Architectural state
    logic [4:0] nzcvq;
    logic [3:0] ge;
    logic t_bit;
    psr_xs_e xs_mode;
    logic [7:0] xs_cond;
    logic [3:0] xs_resume;
    // Next values
    logic next_t_bit;
    psr_xs_e next_xs_mode;
    logic [7:0] next_xs_cond;
    logic [3:0] next_xs_resume;
    logic [31:0] next_psr_word;
    logic [31:0] next_sw_rdata;
    logic next_sw_rvalid;
    logic [31:0] next_stack_word;
    logic next_stack_valid;
    logic next_exc_reject;
    // Qualified software flag write
    logic sw_flag_wr;
    logic [31:0] rd_mask;

    // Build the full word; reserved positions stay zero
    function automatic logic [31:0] build_word(
        input logic [4:0] f, input logic [3:0] g, input logic t, input psr_xs_e m,
        input logic [7:0] c, input logic [3:0] r, input logic [8:0] x);
        logic [31:0] w;
        w = 32'h00000000;
        w[PSR_N_BIT -: 5] = f;
        w[PSR_GE_MSB -: 4] = g;
        w[PSR_T_BIT] = t;
        w[PSR_EXC_MSB -: PSR_EXC_W] = x;
        case (m)
            PSR_XS_COND: begin
                // Conditional block uses all eight shared bits
                w[PSR_XS_HI_MSB -: 2] = c[7:6];
                w[PSR_XS_LO_MSB -: 6] = c[5:0];
            end
            PSR_XS_RESUME: begin
                // Only the next register number; others stay zero
                w[PSR_RESUME_MSB -: 4] = r;
            end
            default: begin
                w[PSR_T_BIT] = t;
            end
        endcase
        return w;
    endfunction : build_word

    // Flag and exception units
    psr_flag_unit u_flag (
        .f(u.flag_mp)
    );
    psr_exc_unit #(
        .NUM_IRQ(NUM_IRQ)
    ) u_exc (
        .e(u.exc_mp)
    );

    // Drive the unit inputs
    always_comb begin
        // Writes reach state only through a view that holds the flags
        sw_flag_wr = sw_wr && sw_sel[PSR_SEL_FLAGS];
        u.nzcv_we = nzcv_we;
        u.nzcv = nzcv_in;
        u.ge_we = ge_we;
        u.ge = ge_in;
        u.sat_evt = sat_evt;
        u.sw_wr = sw_flag_wr;
        u.sw_wr_ge = sw_wr_ge;
        u.sw_wdata = sw_wdata;
        u.cur_nzcvq = nzcvq;
        u.cur_ge = ge;
        u.enter = exc_enter;
        u.is_irq = exc_is_irq;
        u.num_in = exc_num_in;
        u.leave = exc_exit;
        u.ret_num = exc_ret_num;
        // Software data never reaches the number field
        u.cur_num = exc_num;
    end

    // Execution state next values; software has no path here
    always_comb begin
        next_t_bit = t_we ? t_in : t_bit;
        next_xs_mode = xs_mode;
        next_xs_cond = xs_cond;
        next_xs_resume = xs_resume;
        if (xs_we) begin
            // One use at a time; the unused store is cleared
            next_xs_mode = xs_mode_in;
            next_xs_cond = (xs_mode_in == PSR_XS_COND) ? xs_cond_in : PSR_COND_RST;
            next_xs_resume = (xs_mode_in == PSR_XS_RESUME) ? xs_resume_in : PSR_RESUME_RST;
        end
    end

    // Execution state registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            t_bit <= PSR_T_RST;
            xs_mode <= PSR_XS_NONE;
            xs_cond <= PSR_COND_RST;
            xs_resume <= PSR_RESUME_RST;
        end else begin
            t_bit <= next_t_bit;
            xs_mode <= next_xs_mode;
            xs_cond <= next_xs_cond;
            xs_resume <= next_xs_resume;
        end
    end

    // Flags, word, read port and stacking next values
    always_comb begin
        next_psr_word = build_word(u.next_nzcvq, u.next_ge, next_t_bit, next_xs_mode,
            next_xs_cond, next_xs_resume, u.next_num);
        // The execution view is never visible to software
        rd_mask = (sw_sel[PSR_SEL_FLAGS] ? PSR_FLAGS_MASK : 32'h00000000)
            | (sw_sel[PSR_SEL_EXC] ? PSR_EXC_MASK : 32'h00000000);
        next_sw_rdata = sw_rd ? (psr_word & rd_mask) : 32'h00000000;
        next_sw_rvalid = sw_rd;
        // Stack the word as it stood before entry, exec bits included
        next_stack_valid = u.accept;
        next_stack_word = u.accept ? psr_word : stack_word;
        next_exc_reject = u.reject;
    end

    // Flags, word, read port and stacking registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nzcvq <= PSR_NZCVQ_RST;
            ge <= PSR_GE_RST;
            exc_num <= PSR_EXC_THREAD;
            psr_word <= {7'h00, PSR_T_RST, 24'h000000};
            sw_rdata <= 32'h00000000;
            sw_rvalid <= 1'b0;
            stack_word <= 32'h00000000;
            stack_valid <= 1'b0;
            exc_reject <= 1'b0;
        end else begin
            nzcvq <= u.next_nzcvq;
            ge <= u.next_ge;
            exc_num <= u.next_num;
            psr_word <= next_psr_word;
            sw_rdata <= next_sw_rdata;
            sw_rvalid <= next_sw_rvalid;
            stack_word <= next_stack_word;
            stack_valid <= next_stack_valid;
            exc_reject <= next_exc_reject;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_exec_read_zero: assert property (
        sw_rvalid |-> (sw_rdata[26:24] == 3'h0) && (sw_rdata[15:9] == 7'h00))
        else $error("execution view visible to software");
    chk_nzcv_update: assert property (
        nzcv_we |=> (psr_word[31:28] == $past(nzcv_in)) && (nzcvq[4:1] == $past(nzcv_in)))
        else $error("condition flags not taken from result");
    chk_q_sticky: assert property (
        nzcvq[0] && !(sw_flag_wr && !sw_wdata[PSR_Q_BIT]) |=> nzcvq[0])
        else $error("saturation flag cleared by hardware");
    chk_q_set_wins: assert property (
        sat_evt |=> psr_word[PSR_Q_BIT] && $past(sat_evt))
        else $error("saturation event lost");
    chk_ge_update: assert property (
        ge_we |=> psr_word[19:16] == $past(ge_in))
        else $error("byte lane flags not updated");
    chk_no_reserved_num: assert property (
        !(exc_num inside {9'h001, 9'h007, 9'h008, 9'h009, 9'h00A, 9'h00C, 9'h00D}))
        else $error("reserved exception number reported");
    chk_irq_number_map: assert property (
        exc_enter && exc_is_irq && (exc_num_in < 9'(NUM_IRQ))
        |=> (exc_num == $past(exc_num_in) + 9'h010) && stack_valid)
        else $error("interrupt line mapped to wrong number");
    chk_sw_num_ignored: assert property (
        sw_wr && !exc_enter && !exc_exit |=> $stable(exc_num))
        else $error("software changed exception number");
    // Word and mode load on the same edge, so they are compared in one cycle;
    // a look one cycle later would trip on a legal reload of the shared bits
    chk_resume_zero: assert property (
        xs_mode == PSR_XS_RESUME |-> (psr_word[26:25] == 2'h0) && (psr_word[11:10] == 2'h0))
        else $error("resume state leaks into zero bits");
    // The pulse follows the entry edge by one, so the word seen at that edge is wanted
    chk_stack_word: assert property (
        stack_valid |-> stack_word == $past(psr_word))
        else $error("stacked word differs from pre-entry word");
    chk_read_only_view: assert property (
        sw_wr && !sw_sel[PSR_SEL_FLAGS] && !nzcv_we && !sat_evt |=> $stable(nzcvq))
        else $error("write through read-only view changed flags");
    // A refused number must leave the field and the stack alone
    chk_reject_holds: assert property (
        exc_reject |-> $stable(exc_num) && !stack_valid)
        else $error("refused number changed state");
    // The number field of the word tracks the live number
    chk_word_num_field: assert property (
        psr_word[PSR_EXC_MSB:0] == exc_num)
        else $error("number field differs from exception number");
    // Instruction-set state sits at its own bit
    chk_t_bit_place: assert property (
        psr_word[PSR_T_BIT] == t_bit)
        else $error("instruction-set state bit misplaced");
    // Gaps between the fields stay zero whatever the state
    chk_reserved_zero: assert property (
        (psr_word[23:20] == 4'h0) && (psr_word[9] == 1'b0))
        else $error("reserved bit set in status word");
    // Conditional block state fills both shared bit groups
    chk_cond_bits: assert property (
        xs_mode == PSR_XS_COND |-> {psr_word[26:25], psr_word[15:10]} == xs_cond)
        else $error("conditional block state misplaced");

    cov_sat_vs_clear: cover property (sat_evt && sw_flag_wr && !sw_wdata[PSR_Q_BIT]);
    cov_irq_entry: cover property (exc_enter && exc_is_irq ##1 stack_valid);
    // Entry while a multiple transfer is parked, the case that fault handlers inspect
    cov_resume_state: cover property (xs_mode == PSR_XS_RESUME && exc_enter ##1 stack_valid);
    cov_sw_read: cover property (sw_rd && sw_sel == 3'h7);

endmodule : psr_top
`default_nettype wire

/* tb/psr_exec_model.sv */
`timescale 1ns/100ps
`default_nettype none
module psr_exec_model (
    // Clock
    input wire logic clk_sys,
    // Flag updates
    output logic nzcv_we,
    output logic [3:0] nzcv_in,
    output logic ge_we,
    output logic [3:0] ge_in,
    output logic sat_evt,
    // Exception entry and return
    output logic exc_enter,
    output logic exc_is_irq,
    output logic [8:0] exc_num_in,
    output logic exc_exit,
    output logic [8:0] exc_ret_num,
    // Execution state loads
    output logic t_we,
    output logic t_in,
    output logic xs_we,
    output var psr_pkg::psr_xs_e xs_mode_in,
    output logic [7:0] xs_cond_in,
    output logic [3:0] xs_resume_in
);
    import psr_pkg::*;

    // Drop strobes and invert data, so a design that samples stale data is caught
    task automatic idle();
        nzcv_we = 1'b0;
        ge_we = 1'b0;
        sat_evt = 1'b0;
        exc_enter = 1'b0;
        exc_exit = 1'b0;
        t_we = 1'b0;
        xs_we = 1'b0;
        nzcv_in = ~nzcv_in;
        ge_in = ~ge_in;
        exc_num_in = ~exc_num_in;
        exc_ret_num = ~exc_ret_num;
        xs_cond_in = ~xs_cond_in;
        xs_resume_in = ~xs_resume_in;
    endtask : idle

    // Everything quiet from time zero
    initial begin
        nzcv_in = 4'h0;
        ge_in = 4'h0;
        exc_is_irq = 1'b0;
        exc_num_in = 9'h000;
        exc_ret_num = 9'h000;
        t_in = 1'b1;
        xs_mode_in = PSR_XS_NONE;
        xs_cond_in = 8'h00;
        xs_resume_in = 4'h0;
        idle();
    end

    // One-cycle flag update; saturation only ever raised as an event
    task automatic flags(input logic wn, input logic [3:0] n, input logic wg,
                         input logic [3:0] g, input logic sat);
        @(negedge clk_sys);
        nzcv_we = wn;
        nzcv_in = n;
        ge_we = wg;
        ge_in = g;
        sat_evt = sat;
        @(negedge clk_sys);
        idle();
    endtask : flags

    // Exception entry, by number or by interrupt line
    task automatic enter(input logic irq, input logic [8:0] num);
        @(negedge clk_sys);
        exc_enter = 1'b1;
        exc_is_irq = irq;
        exc_num_in = num;
        @(negedge clk_sys);
        idle();
    endtask : enter

    // Exception return to the given number
    task automatic leave(input logic [8:0] num);
        @(negedge clk_sys);
        exc_exit = 1'b1;
        exc_ret_num = num;
        @(negedge clk_sys);
        idle();
    endtask : leave

    // Instruction-set state load
    task automatic tload(input logic t);
        @(negedge clk_sys);
        t_we = 1'b1;
        t_in = t;
        @(negedge clk_sys);
        idle();
    endtask : tload

    // Shared execution-state load
    task automatic xload(input psr_xs_e m, input logic [7:0] c, input logic [3:0] r);
        @(negedge clk_sys);
        xs_we = 1'b1;
        xs_mode_in = m;
        xs_cond_in = c;
        xs_resume_in = r;
        @(negedge clk_sys);
        idle();
    endtask : xload
endmodule : psr_exec_model
`default_nettype wire

/* tb/psr_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module psr_tb_top;
    import psr_pkg::*;
    localparam int NIRQ = 32; // Small line count so the top line is reachable
    logic clk_sys, arst_n, nzcv_we, ge_we, sat_evt, exc_enter, exc_is_irq, exc_exit;
    logic t_we, t_in, xs_we, sw_rd, sw_wr, sw_wr_ge, sw_rvalid, stack_valid, exc_reject;
    logic [3:0] nzcv_in, ge_in, xs_resume_in;
    logic [8:0] exc_num_in, exc_ret_num, exc_num;
    logic [7:0] xs_cond_in;
    logic [2:0] sw_sel;
    logic [31:0] sw_wdata, sw_rdata, psr_word, stack_word, s, prev;
    psr_xs_e xs_mode_in;
    // Expected state kept by the bench
    logic [4:0] e_f;
    logic [3:0] e_ge;
    logic e_t;
    logic [8:0] e_exc;
    logic [31:0] e_xs;
    int fail_count, n_compared, cyc;
    logic [8:0] legal[8] = '{9'h002, 9'h003, 9'h004, 9'h005, 9'h006, 9'h00B, 9'h00E, 9'h00F};
    logic [8:0] resvd[7] = '{9'h001, 9'h007, 9'h008, 9'h009, 9'h00A, 9'h00C, 9'h00D};

    psr_top #(.NUM_IRQ(NIRQ)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
        .nzcv_we(nzcv_we), .nzcv_in(nzcv_in), .ge_we(ge_we), .ge_in(ge_in),
        .sat_evt(sat_evt), .exc_enter(exc_enter), .exc_is_irq(exc_is_irq),
        .exc_num_in(exc_num_in), .exc_exit(exc_exit), .exc_ret_num(exc_ret_num),
        .t_we(t_we), .t_in(t_in), .xs_we(xs_we), .xs_mode_in(xs_mode_in),
        .xs_cond_in(xs_cond_in), .xs_resume_in(xs_resume_in), .sw_rd(sw_rd),
        .sw_wr(sw_wr), .sw_sel(sw_sel), .sw_wr_ge(sw_wr_ge), .sw_wdata(sw_wdata),
        .sw_rdata(sw_rdata), .sw_rvalid(sw_rvalid), .psr_word(psr_word), .exc_num(exc_num),
        .stack_word(stack_word), .stack_valid(stack_valid), .exc_reject(exc_reject));

    psr_exec_model model_u (.clk_sys(clk_sys), .nzcv_we(nzcv_we), .nzcv_in(nzcv_in),
        .ge_we(ge_we), .ge_in(ge_in), .sat_evt(sat_evt), .exc_enter(exc_enter),
        .exc_is_irq(exc_is_irq), .exc_num_in(exc_num_in), .exc_exit(exc_exit),
        .exc_ret_num(exc_ret_num), .t_we(t_we), .t_in(t_in), .xs_we(xs_we),
        .xs_mode_in(xs_mode_in), .xs_cond_in(xs_cond_in), .xs_resume_in(xs_resume_in));

    // 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Galois shift register, fixed start keeps runs repeatable
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {1'b0, v[31:1]} ^ (v[0] ? 32'h80200003 : 32'h00000000);
    endfunction : lfsr

    // Full status word as the bench expects it
    function automatic logic [31:0] exp_word();
        return {e_f, 27'h0} | {12'h0, e_ge, 16'h0} | {7'h0, e_t, 24'h0} | e_xs | {23'h0, e_exc};
    endfunction : exp_word

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t pulse got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    // Whole word and exception number against the bench state
    task automatic chk_state();
        chk_word(psr_word, exp_word());
        chk_word({23'h0, exc_num}, {23'h0, e_exc});
    endtask : chk_state

    // One software move; reads see only the views that the select enables
    task automatic sw_move(input logic rd, input logic [2:0] sel, input logic ge,
                           input logic [31:0] d);
        logic [31:0] m;
        m = (sel[0] ? PSR_FLAGS_MASK : 32'h0) | (sel[1] ? PSR_EXC_MASK : 32'h0);
        @(negedge clk_sys);
        sw_rd = rd;
        sw_wr = ~rd;
        sw_sel = sel;
        sw_wr_ge = ge;
        sw_wdata = d;
        @(negedge clk_sys);
        sw_rd = 1'b0;
        sw_wr = 1'b0;
        sw_wdata = ~d;
        chk_bit(sw_rvalid, rd);
        if (rd) begin
            chk_word(sw_rdata, exp_word() & m);
        end else if (sel[0]) begin
            e_f = d[31:27];
            e_ge = ge ? d[19:16] : e_ge;
        end
        chk_state();
    endtask : sw_move

    // Entry with the expected outcome: accepted and stacked, or refused
    task automatic entry(input logic irq, input logic [8:0] n, input logic ok,
                         input logic [8:0] rep);
        prev = exp_word();
        model_u.enter(irq, n);
        chk_bit(stack_valid, ok);
        chk_bit(exc_reject, ~ok);
        if (ok) begin
            chk_word(stack_word, prev);
            e_exc = rep;
        end
        chk_state();
    endtask : entry

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    // Hang guard, well above the roughly 170 cycles the run needs
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        {arst_n, sw_rd, sw_wr, sw_wr_ge, sw_sel, sw_wdata} = '0;
        {fail_count, n_compared, cyc} = '0;
        {e_f, e_ge, e_exc, e_xs} = '0;
        e_t = 1'b1;
        s = 32'hED90115B;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        chk_state();
        // Random flag loads mixed with reads through every view select
        repeat (24) begin
            s = lfsr(s);
            model_u.flags(1'b1, s[3:0], 1'b1, s[7:4], 1'b0);
            e_f[4:1] = s[3:0];
            e_ge = s[7:4];
            chk_state();
            sw_move(1'b1, s[10:8], 1'b0, 32'h0);
        end
        // Sticky saturation survives later flag loads
        model_u.flags(1'b0, 4'h0, 1'b0, 4'h0, 1'b1);
        e_f[0] = 1'b1;
        chk_state();
        model_u.flags(1'b1, 4'h0, 1'b1, 4'h0, 1'b0);
        e_f[4:1] = 4'h0;
        e_ge = 4'h0;
        chk_state();
        // Saturation event and software clear on the same edge: the set wins
        fork
            model_u.flags(1'b0, 4'h0, 1'b0, 4'h0, 1'b1);
            begin
                @(negedge clk_sys);
                {sw_wr, sw_sel, sw_wr_ge, sw_wdata} = {1'b1, 3'b001, 1'b0, 32'h00000000};
                @(negedge clk_sys);
                sw_wr = 1'b0;
            end
        join
        e_f = 5'h01;
        chk_state();
        // Every system number, then every reserved one
        foreach (legal[i]) entry(1'b0, legal[i], 1'b1, legal[i]);
        foreach (resvd[i]) entry(1'b0, resvd[i], 1'b0, 9'h0);
        // Interrupt lines: both ends, random middle, one past the top
        entry(1'b1, 9'h000, 1'b1, PSR_EXC_IRQ_BASE);
        entry(1'b1, 9'(NIRQ - 1), 1'b1, 9'(NIRQ + 15));
        repeat (4) begin
            s = lfsr(s);
            entry(1'b1, 9'(s % NIRQ), 1'b1, 9'(s % NIRQ + 16));
        end
        entry(1'b1, 9'(NIRQ), 1'b0, 9'h0);
        // Execution state: resume then conditional use of the shared bits
        s = lfsr(s);
        model_u.xload(PSR_XS_RESUME, s[7:0], s[11:8]);
        e_xs = {16'h0, s[11:8], 12'h0};
        chk_state();
        entry(1'b0, PSR_EXC_HARD, 1'b1, PSR_EXC_HARD);
        model_u.xload(PSR_XS_COND, s[19:12], s[23:20]);
        e_xs = {5'h0, s[19:18], 9'h0, s[17:12], 10'h0};
        chk_state();
        model_u.tload(1'b0);
        e_t = 1'b0;
        chk_state();
        entry(1'b0, PSR_EXC_SVC, 1'b1, PSR_EXC_SVC);
        sw_move(1'b1, 3'b111, 1'b0, 32'h0);
        // Software writes: refused select, all-ones, then clearing saturation
        sw_move(1'b0, 3'b110, 1'b1, 32'h00000000);
        sw_move(1'b0, 3'b111, 1'b1, 32'hFFFFFFFF);
        sw_move(1'b0, 3'b001, 1'b0, 32'h00000000);
        // Illegal return refused, return to thread accepted
        model_u.leave(9'h007);
        chk_bit(exc_reject, 1'b1);
        chk_state();
        model_u.leave(PSR_EXC_THREAD);
        e_exc = 9'h000;
        chk_state();
        results();
    end
endmodule : psr_tb_top
`default_nettype wire
